// [logic/wwd_pkg.sv]
// Package for the window watchdog: register map, fields, reset values, timing.
// Assumes a single 25 MHz APB clock and an active-low asynchronous reset.
package wwd_pkg;

	// ****************************************
	// Bus carrier
	// ****************************************
	localparam int ADDR_W = 8;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} wwd_apb_req_s;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} wwd_apb_rsp_s;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_WINDOW  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h08;

	// ****************************************
	// Fields
	// ****************************************
	localparam int CNT_W        = 7;
	localparam int BIT_TOP      = 6;
	localparam int BIT_ACTIVATE = 7;
	localparam int ST_ACTIVE    = 0;
	localparam int ST_HW_OPT    = 1;
	localparam int ST_HALT_OPT  = 2;
	localparam int ST_PULSE     = 3;
	localparam int ST_WDG_RST   = 4;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [CNT_W-1:0] RST_COUNTER = 7'h7F;
	localparam logic [CNT_W-1:0] RST_WINDOW  = 7'h7F;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS   = 40;
	localparam int TICK_OSC_CYCLES = 16384;
	localparam int RST_PULSE_NS    = 30000;
	localparam int RST_PULSE_CYC   = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_W         = $clog2(RST_PULSE_CYC + 1);

	typedef enum logic [0:0] {
		WWD_RUN,
		WWD_PULSE
	} wwd_state_e;

endpackage

// [logic/wwd_divider.sv]
// Fixed divider producing a one-cycle tick every DIV clock cycles.
// Assumes DIV of at least two; free running from reset release.
`timescale 1ns/1ns
module wwd_divider #(
	parameter int DIV = 16384
) (
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      tick
);
	localparam int W = $clog2(DIV);

	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic         next_tick;

	always_comb begin
		next_tick = (cnt == W'(DIV - 1));
		next_cnt  = next_tick ? '0 : cnt + W'(1);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule

// [logic/wwd_top.sv]
// Window watchdog: 7-bit downcounter, window compare, reset pulse, APB slave.
// Assumes option inputs are static straps from outside the clock domain.
//
// Overview of operation
// - counter decrements every 16384 oscillator cycles
// - activated, top bit clearing starts reset
// - reset pin driven low about 30 us
// - reload above window value forces reset
// - counter lives in control bits six..zero
// - timeout set in 64 steps, low bits
// - option selects hardware or software activation
// - option makes halt cause reset instead, once activated
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
module wwd_top
	import wwd_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_OSC_CYCLES
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire wwd_pkg::wwd_apb_req_s apb_req,
	output wwd_pkg::wwd_apb_rsp_s      apb_rsp,
	input  wire logic                  hw_activate_option,
	input  wire logic                  halt_reset_option,
	input  wire logic                  halt_req,
	output logic                       halt_ack,
	output logic                       reset_pin_out,
	output logic                       reset_pin_oe
);
	import wwd_pkg::*;

	// ****************************************
	// Option synchronisers
	// ****************************************
	logic [1:0] hw_sync;
	logic [1:0] halt_opt_sync;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hw_sync       <= 2'h0;
			halt_opt_sync <= 2'h0;
		end else begin
			hw_sync       <= {hw_sync[0], hw_activate_option};
			halt_opt_sync <= {halt_opt_sync[0], halt_reset_option};
		end
	end

	// ****************************************
	// Timebase
	// ****************************************
	logic tick;

	wwd_divider #(
		.DIV (TICK_CYCLES)
	) u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (tick)
	);

	// ****************************************
	// Bus decode
	// ****************************************
	logic bus_access;
	logic bus_wr;
	logic wr_control;
	logic wr_window;
	logic wr_status;
	logic addr_ok;

	always_comb begin
		bus_access = apb_req.psel && apb_req.penable && !apb_rsp.pready;
		bus_wr     = bus_access && apb_req.pwrite;
		addr_ok    = (apb_req.paddr == OFS_CONTROL) || (apb_req.paddr == OFS_WINDOW)
		             || (apb_req.paddr == OFS_STATUS);
		wr_control = bus_wr && (apb_req.paddr == OFS_CONTROL);
		wr_window  = bus_wr && (apb_req.paddr == OFS_WINDOW);
		wr_status  = bus_wr && (apb_req.paddr == OFS_STATUS);
	end

	// ****************************************
	// Watchdog core
	// ****************************************
	logic [CNT_W-1:0]   counter;
	logic [CNT_W-1:0]   window;
	logic               activate;
	logic               wdg_rst_seen;
	wwd_state_e         state;
	logic [PULSE_W-1:0] pulse_cnt;

	logic [CNT_W-1:0]   next_counter;
	logic [CNT_W-1:0]   next_window;
	logic               next_activate;
	logic               next_wdg_rst_seen;
	wwd_state_e         next_state;
	logic [PULSE_W-1:0] next_pulse_cnt;
	logic               next_halt_ack;
	logic               fire;
	logic               halt_fire;

	always_comb begin
		next_counter      = counter;
		next_window       = window;
		next_activate     = activate;
		next_wdg_rst_seen = wdg_rst_seen;
		next_state        = state;
		next_pulse_cnt    = pulse_cnt;
		next_halt_ack     = 1'b0;
		fire              = 1'b0;
		halt_fire         = 1'b0;

		if (tick) begin
			next_counter = counter - 7'h01;
			if (activate && counter[BIT_TOP] && !next_counter[BIT_TOP]) begin
				fire = 1'b1;
			end
		end

		if (wr_control) begin
			next_counter = apb_req.pwdata[CNT_W-1:0];
			if (apb_req.pwdata[BIT_ACTIVATE]) begin
				next_activate = 1'b1;
			end
			if (activate && (counter > window)) begin
				fire = 1'b1;
			end
			if (next_activate && !apb_req.pwdata[BIT_TOP]) begin
				fire = 1'b1;
			end
		end

		if (wr_window) begin
			next_window = apb_req.pwdata[CNT_W-1:0];
		end

		if (hw_sync[1]) begin
			next_activate = 1'b1;
		end

		if (halt_req) begin
			if (halt_opt_sync[1] && activate) begin
				halt_fire = 1'b1;
			end else begin
				next_halt_ack = 1'b1;
			end
		end

		if (wr_status && apb_req.pwdata[ST_WDG_RST]) begin
			next_wdg_rst_seen = 1'b0;
		end

		case (state)
			WWD_RUN: begin
				if (fire || halt_fire) begin
					next_state        = WWD_PULSE;
					next_pulse_cnt    = PULSE_W'(RST_PULSE_CYC - 1);
					next_wdg_rst_seen = 1'b1;
				end
			end
			WWD_PULSE: begin
				if (pulse_cnt == '0) begin
					next_state = WWD_RUN;
				end else begin
					next_pulse_cnt = pulse_cnt - PULSE_W'(1);
				end
			end
			default: begin
				next_state = WWD_RUN;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter       <= RST_COUNTER;
			window        <= RST_WINDOW;
			activate      <= 1'b0;
			wdg_rst_seen  <= 1'b0;
			state         <= WWD_RUN;
			pulse_cnt     <= '0;
			halt_ack      <= 1'b0;
			reset_pin_out <= 1'b1;
			reset_pin_oe  <= 1'b0;
		end else begin
			counter       <= next_counter;
			window        <= next_window;
			activate      <= next_activate;
			wdg_rst_seen  <= next_wdg_rst_seen;
			state         <= next_state;
			pulse_cnt     <= next_pulse_cnt;
			halt_ack      <= next_halt_ack;
			reset_pin_out <= 1'b0;
			reset_pin_oe  <= (next_state == WWD_PULSE);
		end
	end

	// ****************************************
	// Bus answer
	// ****************************************
	wwd_apb_rsp_s next_rsp;

	always_comb begin
		next_rsp = '0;
		if (bus_access) begin
			next_rsp.pready  = 1'b1;
			next_rsp.pslverr = !addr_ok;
			if (!apb_req.pwrite) begin
				case (apb_req.paddr)
					OFS_CONTROL: next_rsp.prdata = {24'h000000, activate, counter};
					OFS_WINDOW:  next_rsp.prdata = {25'h0000000, window};
					OFS_STATUS: begin
						next_rsp.prdata[ST_ACTIVE]   = activate;
						next_rsp.prdata[ST_HW_OPT]   = hw_sync[1];
						next_rsp.prdata[ST_HALT_OPT] = halt_opt_sync[1];
						next_rsp.prdata[ST_PULSE]    = (state == WWD_PULSE);
						next_rsp.prdata[ST_WDG_RST]  = wdg_rst_seen;
					end
					default: next_rsp.prdata = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp <= next_rsp;
		end
	end
endmodule

// [verif/wwd_checker.sv]
// Checker for the window watchdog: bus answer timing, reset pulse, halt.
// Assumes binding to wwd_top; sees only its ports.
`timescale 1ns/1ns
module wwd_checker
	import wwd_pkg::*;
#(
	parameter int TICK_CYCLES = 16
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire wwd_pkg::wwd_apb_req_s apb_req,
	input wire wwd_pkg::wwd_apb_rsp_s apb_rsp,
	input wire logic                  hw_activate_option,
	input wire logic                  halt_reset_option,
	input wire logic                  halt_req,
	input wire logic                  halt_ack,
	input wire logic                  reset_pin_out,
	input wire logic                  reset_pin_oe
);
	// ****************************************
	// Pulse length counter
	// ****************************************
	logic [9:0] len;
	logic [9:0] next_len;
	always_comb begin
		next_len = reset_pin_oe ? len + 10'h001 : 10'h000;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			len <= 10'h000;
		end else begin
			len <= next_len;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_after_access_a: assert property (
		apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
		else $error("pready late");
	ready_one_cycle_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready held");
	idle_data_zero_a: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
		else $error("prdata not zero");
	error_with_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("pslverr alone");
	pulse_length_a: assert property (
		$fell(reset_pin_oe) |-> len == 10'(RST_PULSE_CYC))
		else $error("pulse length");
	pulse_bound_a: assert property (reset_pin_oe |-> len < 10'(RST_PULSE_CYC))
		else $error("pulse too long");
	halt_ack_cause_a: assert property (halt_ack |-> $past(halt_req))
		else $error("halt_ack uncaused");
	pin_data_low_a: assert property ($past(presetn) |-> !reset_pin_out)
		else $error("pin data high");
	cover property ($rose(reset_pin_oe));
	cover property (halt_ack);
	cover property (apb_rsp.pslverr);
endmodule
bind wwd_top wwd_checker #(.TICK_CYCLES(TICK_CYCLES)) wwd_checker_inst (.pclk, .presetn,
	.apb_req, .apb_rsp, .hw_activate_option, .halt_reset_option, .halt_req, .halt_ack,
	.reset_pin_out, .reset_pin_oe);

// [verif/window_watchdog_tb.sv]
// Bench for the window watchdog: APB register tasks, pulse and halt checks.
// Assumes wwd_top with a short tick period and one 25 MHz clock.
`timescale 1ns/1ns
module window_watchdog_tb;
	import wwd_pkg::*;
	localparam int TK = 16;
	logic         pclk     = 1'b0;
	logic         presetn  = 1'b0;
	wwd_apb_req_s req      = '0;
	wwd_apb_rsp_s rsp;
	logic         hw_opt   = 1'b0;
	logic         halt_opt = 1'b0;
	logic         hreq     = 1'b0;
	logic         hack;
	logic         pin_out;
	logic         pin_oe;
	int           n_mismatch = 0;
	int           n_tests    = 0;
	int           seed       = 87940;
	int           n;
	logic [31:0]  rd;
	logic [31:0]  v;
	logic         er;
	logic [31:0]  exp_q[$];
	always #20 pclk = ~pclk;
	wwd_top #(.TICK_CYCLES(TK)) wwd_top_inst (.pclk(pclk), .presetn(presetn),
		.apb_req(req), .apb_rsp(rsp), .hw_activate_option(hw_opt),
		.halt_reset_option(halt_opt), .halt_req(hreq), .halt_ack(hack),
		.reset_pin_out(pin_out), .reset_pin_oe(pin_oe));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		for (k = 0; k < 20 && rsp.pready !== 1'b1; k++) @(posedge pclk);
		if (k == 20) begin
			n_mismatch++;
			finish_test();
		end
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wait_oe(input logic lv, input int lim);
		for (n = 0; n < lim && pin_oe !== lv; n++) @(posedge pclk);
		if (n == lim) begin
			n_mismatch++;
			finish_test();
		end
	endtask
	task automatic rst(input logic hw);
		@(posedge pclk);
		presetn <= 1'b0;
		hw_opt <= hw;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic hlt(input logic ack);
		@(posedge pclk);
		hreq <= 1'b1;
		@(posedge pclk);
		hreq <= 1'b0;
		@(posedge pclk);
		chk("halt_ack", ack, hack);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst(1'b0);
		apb(0, OFS_CONTROL, 0);
		chk("control", 32'h7F, rd);
		apb(0, OFS_WINDOW, 0);
		chk("window", 32'h7F, rd);
		apb(0, 8'h0C, 0);
		chk("pslverr", 1, er);
		$display("test reset values done");
		apb(1, OFS_CONTROL, 32'h7F);
		repeat (4 * TK) @(posedge pclk);
		apb(0, OFS_CONTROL, 0);
		chk("ticks", 1, (7'h7F - rd[6:0]) inside {7'h04, 7'h05});
		for (int j = 0; j < 3; j++) begin
			v = $random(seed);
			exp_q.push_back({25'h0, v[6:0]});
			apb(1, OFS_WINDOW, v);
			apb(0, OFS_WINDOW, 0);
			chk("window", exp_q.pop_front(), rd);
		end
		$display("test count and window done");
		apb(1, OFS_WINDOW, 32'h7F);
		apb(1, OFS_CONTROL, 32'hFF);
		apb(0, OFS_STATUS, 0);
		chk("active", 1, rd[ST_ACTIVE]);
		chk("pin_oe", 0, pin_oe);
		apb(1, OFS_WINDOW, 32'h50);
		apb(1, OFS_CONTROL, 32'h7F);
		wait_oe(1, 10);
		wait_oe(0, 800);
		chk("pulse", RST_PULSE_CYC, n);
		apb(0, OFS_CONTROL, 0);
		chk("sticky", 1, rd[BIT_ACTIVATE]);
		apb(0, OFS_STATUS, 0);
		chk("wdg_rst", 1, rd[ST_WDG_RST]);
		apb(1, OFS_STATUS, 32'h1 << ST_WDG_RST);
		apb(0, OFS_STATUS, 0);
		chk("wdg_rst_clr", 0, rd[ST_WDG_RST]);
		$display("test early reload done");
		rst(1'b0);
		apb(1, OFS_CONTROL, 32'hFF);
		chk("pin_oe", 0, pin_oe);
		apb(1, OFS_CONTROL, 32'h3F);
		wait_oe(1, 4);
		chk("pin_oe", 1, pin_oe);
		wait_oe(0, 800);
		$display("test top bit clear done");
		rst(1'b0);
		apb(1, OFS_CONTROL, 32'hC1);
		wait_oe(1, 3 * TK + 4);
		chk("timeout", 1, n > TK && n <= 2 * TK);
		wait_oe(0, 800);
		$display("test timeout done");
		halt_opt <= 1'b1;
		rst(1'b0);
		hlt(1'b1);
		rst(1'b1);
		repeat (4) @(posedge pclk);
		apb(0, OFS_STATUS, 0);
		chk("hw_active", 32'h7, rd & 32'h7);
		hlt(1'b0);
		wait_oe(1, 4);
		chk("pin_oe", 1, pin_oe);
		apb(0, OFS_STATUS, 0);
		chk("pulse_on", 1, rd[ST_PULSE]);
		$display("test halt done");
		finish_test();
	end
endmodule
